/* verilog/twmsc_ctrl.sv */
// Implementation choice: strobed register access.
`timescale 1ns/10ps
module twmsc_ctrl #(
   parameter int unsigned CLK_HZ = twmsc_pkg::REF_CLK_HZ
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // register port
   input wire twmsc_pkg::twmsc_bus_req_s bus_req,
   output logic [7:0] bus_rdata,
   // two-wire lines
   input wire twmsc_pkg::twmsc_line_s line_i,
   output twmsc_pkg::twmsc_pin_out_s line_o,
   // pin mode and interrupt
   output logic open_drain_en,
   output logic irq
);
   import twmsc_pkg::*;

   localparam logic [CNT_W-1:0] HALF_STD = CNT_W'((CLK_HZ + 2 * RATE_STD_HZ - 1) / (2 * RATE_STD_HZ) - 1);
   localparam logic [CNT_W-1:0] HALF_FAST = CNT_W'((CLK_HZ + 2 * RATE_FAST_HZ - 1) / (2 * RATE_FAST_HZ) - 1);
   localparam logic [CNT_W-1:0] HALF_FPLUS = CNT_W'((CLK_HZ + 2 * RATE_FPLUS_HZ - 1) / (2 * RATE_FPLUS_HZ) - 1);

   if ((CLK_HZ + 2 * RATE_STD_HZ - 1) / (2 * RATE_STD_HZ) > 2 ** CNT_W || CLK_HZ < 8 * RATE_FPLUS_HZ) begin
      $error("twmsc_ctrl: CLK_HZ out of range for the half-period counter");
   end

   typedef struct packed {
      twmsc_line_s s1;
      twmsc_line_s s2;
      twmsc_line_s s3;
      twmsc_ctrl_s cr;
      logic [6:0] own;
      logic gc;
      logic [7:0] data;
      logic [7:0] sreg;
      logic busy;
      logic dir;
      logic sta;
      logic stp;
      logic pend;
      logic ack;
      twmsc_state_e st;
      logic [3:0] bitn;
      logic ph;
      logic addr;
      logic [CNT_W-1:0] cnt;
      logic [7:0] rdata;
      logic scl_drv;
      logic sda_drv;
   } twmsc_regs_s;

   localparam twmsc_regs_s REGS_RST = '{s1: '1, s2: '1, s3: '1, own: ID_RESET[7:1], gc: ID_RESET[ID_GC],
      st: ST_IDLE, default: '0};

   twmsc_regs_s q;
   twmsc_regs_s d;
   logic bus_idle;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic tick;
   logic xfer;
   logic tx;
   logic irq_flag;
   logic [7:0] w;
   logic [7:0] sr_val;

   function automatic logic [CNT_W-1:0] half_last(input logic [1:0] rate);
      case (rate)
         RATE_FAST: half_last = HALF_FAST;
         RATE_FPLUS: half_last = HALF_FPLUS;
         default: half_last = HALF_STD; // [RULE2] [RULE23]
      endcase
   endfunction

   assign w = bus_req.wdata;
   assign bus_idle = q.s2.scl && q.s2.sda; // [RULE3]
   assign scl_rise = q.s2.scl && !q.s3.scl;
   assign scl_fall = !q.s2.scl && q.s3.scl;
   assign start_det = q.s2.scl && q.s3.scl && !q.s2.sda && q.s3.sda;
   assign stop_det = q.s2.scl && q.s3.scl && q.s2.sda && !q.s3.sda;
   assign tick = q.cnt >= half_last(q.cr.rate);
   assign xfer = !(q.st == ST_IDLE || q.st == ST_MHOLD);
   assign tx = q.cr.master ? (q.addr || !q.dir) : (!q.addr && q.dir); // [RULE21]
   assign irq_flag = q.pend || (!q.cr.master && q.stp); // [RULE19]
   assign sr_val = {q.busy, q.dir, 1'b0, q.sta, q.stp, q.pend, q.ack, irq_flag};

   always_comb begin
      d = q;
      d.s1 = line_i;
      d.s2 = q.s1;
      d.s3 = q.s2;
      d.cnt = CNT_W'(q.cnt + 1'b1);
      if (bus_req.rd) begin
         case (bus_req.addr)
            OFS_CR: d.rdata = {q.cr.enable, q.cr.master, 3'h0, q.cr.rate, q.cr.irq_en};
            OFS_ID: d.rdata = {q.own, q.gc};
            OFS_DR: d.rdata = q.data; // [RULE22]
            OFS_SR: d.rdata = sr_val;
            default: d.rdata = 8'h00;
         endcase
      end
      if (bus_req.wr) begin
         case (bus_req.addr)
            OFS_CR: begin
               d.cr.enable = w[CR_EN];
               d.cr.master = w[CR_MS];
               d.cr.rate = w[CR_RATE_HI:CR_RATE_LO];
               d.cr.irq_en = w[CR_IE];
            end
            OFS_ID: begin
               d.own = w[7:1]; // [RULE13]
               d.gc = w[ID_GC];
            end
            OFS_DR: d.data = w; // [RULE22]
            OFS_SR: begin
               if (q.cr.master) begin
                  d.dir = w[SR_DIR]; // [RULE21]
                  if (!xfer) begin
                     d.sta = w[SR_STA]; // [RULE10]
                     if (!w[SR_STP] || q.busy) begin
                        d.stp = w[SR_STP]; // [RULE8]
                     end
                  end
               end else begin
                  if (!w[SR_STA]) begin
                     d.sta = 1'b0; // [RULE16]
                  end
                  if (!w[SR_STP]) begin
                     d.stp = 1'b0;
                  end
               end
               if (!w[SR_PEND]) begin
                  d.pend = 1'b0;
               end
               d.ack = w[SR_ACK]; // [RULE18]
            end
            default: ;
         endcase
      end
      case (q.st)
         ST_IDLE: begin
            if (q.cr.master && q.sta) begin
               d.st = ST_MWAIT;
            end
         end
         ST_MWAIT: begin
            d.cnt = '0;
            if (bus_idle) begin
               d.st = ST_MSTART; // [RULE4]
               d.sreg = {q.own, q.dir};
               d.addr = 1'b1;
            end
         end
         ST_MSTART: begin
            if (tick) begin
               d.st = ST_MBIT;
               d.bitn = '0;
               d.ph = 1'b0;
               d.cnt = '0;
               d.busy = 1'b1; // [RULE11]
            end
         end
         ST_MBIT: begin
            if (!q.ph) begin
               if (tick) begin
                  d.ph = 1'b1;
                  d.cnt = '0;
               end
            end else if (!q.s2.scl) begin
               d.cnt = '0;
            end else if (tick) begin
               d.ph = 1'b0;
               d.cnt = '0;
               if (q.bitn != BIT_ACK) begin
                  d.sreg = {q.sreg[6:0], q.s2.sda};
                  d.bitn = 4'(q.bitn + 4'h1);
                  if (q.bitn == BIT_LAST && !tx) begin
                     d.data = {q.sreg[6:0], q.s2.sda}; // [RULE7]
                     d.pend = 1'b1;
                     d.st = ST_MHOLD;
                  end
               end else begin
                  if (tx) begin
                     d.ack = q.s2.sda; // [RULE18]
                  end
                  d.pend = 1'b1; // [RULE5] [RULE6]
                  d.st = ST_MHOLD;
                  d.bitn = '0;
                  if (q.addr) begin
                     d.sta = 1'b0; // [RULE4]
                     d.addr = 1'b0;
                  end
               end
            end
         end
         ST_MHOLD: begin
            d.cnt = '0;
            d.ph = 1'b0;
            if (!q.pend) begin
               if (q.bitn == BIT_ACK) begin
                  d.st = ST_MBIT; // [RULE7]
               end else if (q.stp) begin
                  d.st = ST_MSTOP; // [RULE8]
               end else if (q.sta) begin
                  d.st = ST_MRESTART; // [RULE10]
               end else begin
                  d.st = ST_MBIT; // [RULE6]
                  if (!q.dir) begin
                     d.sreg = q.data;
                  end
               end
            end
         end
         ST_MSTOP, ST_MRESTART: begin
            if (!q.ph) begin
               if (tick) begin
                  d.ph = 1'b1;
                  d.cnt = '0;
               end
            end else if (!q.s2.scl) begin
               d.cnt = '0;
            end else if (tick) begin
               d.cnt = '0;
               d.ph = 1'b0;
               if (q.st == ST_MRESTART) begin
                  d.st = ST_MSTART;
                  d.sreg = {q.own, q.dir};
                  d.addr = 1'b1;
               end else begin
                  d.stp = 1'b0; // [RULE8]
                  d.busy = 1'b0; // [RULE11]
                  d.st = q.sta ? ST_MWAIT : ST_IDLE; // [RULE9]
               end
            end
         end
         ST_SBIT: begin
            if (scl_rise) begin
               if (q.bitn != BIT_ACK && !tx) begin
                  d.sreg = {q.sreg[6:0], q.s2.sda};
               end else if (q.bitn == BIT_ACK && tx) begin
                  d.ack = q.s2.sda; // [RULE18]
               end
            end
            if (scl_fall && q.ph) begin
               d.ph = 1'b0;
            end else if (scl_fall) begin
               if (q.bitn < BIT_LAST) begin
                  d.bitn = 4'(q.bitn + 4'h1);
                  if (tx) begin
                     d.sreg = {q.sreg[6:0], 1'b0};
                  end
               end else if (q.bitn == BIT_LAST) begin
                  d.bitn = BIT_ACK;
                  if (q.addr) begin
                     if (q.sreg[7:1] == q.own || (q.gc && q.sreg[7:1] == GC_ADDR)) begin // [RULE13]
                        d.sta = 1'b1; // [RULE12]
                        d.pend = 1'b1;
                        d.busy = 1'b1; // [RULE11]
                        d.dir = q.sreg[0]; // [RULE21]
                        d.st = ST_SHOLD;
                     end else begin
                        d.st = ST_IDLE;
                     end
                  end else if (!tx) begin
                     d.data = q.sreg; // [RULE15]
                     d.pend = 1'b1;
                     d.st = ST_SHOLD;
                  end
               end else begin
                  d.bitn = '0;
                  d.addr = 1'b0;
                  if (tx) begin
                     d.pend = 1'b1; // [RULE14]
                     d.st = ST_SHOLD;
                  end
               end
            end
         end
         ST_SHOLD: begin
            if (!q.pend) begin
               d.st = ST_SBIT;
               if (q.dir) begin
                  d.sreg = q.data; // [RULE14]
               end
            end
         end
         default: d.st = ST_IDLE;
      endcase
      if (!q.cr.master && q.cr.enable) begin
         if (start_det) begin
            d.st = ST_SBIT; // [RULE17]
            d.bitn = '0;
            d.addr = 1'b1;
            // the clock fall that closes the start carries no bit
            d.ph = 1'b1;
         end else if (stop_det) begin
            d.st = ST_IDLE;
            if (q.busy) begin
               d.stp = 1'b1; // [RULE16]
               d.busy = 1'b0; // [RULE11]
            end
         end
      end
      if (!d.cr.enable) begin
         d.st = ST_IDLE; // [RULE20]
         d.busy = 1'b0;
         d.pend = 1'b0;
         d.sta = 1'b0;
         d.stp = 1'b0;
         d.ack = 1'b0;
      end
      d.scl_drv = q.cr.enable && (q.st == ST_MHOLD || q.st == ST_SHOLD ||
         (!q.ph && (q.st == ST_MBIT || q.st == ST_MSTOP || q.st == ST_MRESTART))); // [RULE5] [RULE12]
      case (q.st)
         ST_MSTART, ST_MSTOP: d.sda_drv = q.cr.enable;
         ST_MBIT, ST_MHOLD, ST_SBIT, ST_SHOLD: begin
            if (q.bitn == BIT_ACK) begin
               d.sda_drv = q.cr.enable && !tx && !q.ack; // [RULE18]
            end else begin
               d.sda_drv = q.cr.enable && tx && !q.sreg[BYTE_MSB];
            end
         end
         default: d.sda_drv = 1'b0;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= REGS_RST;
      end else begin
         q <= d;
      end
   end

   assign bus_rdata = q.rdata;
   assign open_drain_en = q.cr.enable; // [RULE1]
   assign line_o = '{scl_o: 1'b0, scl_oe: q.scl_drv, sda_o: 1'b0, sda_oe: q.sda_drv};
   assign irq = irq_flag && q.cr.irq_en; // [RULE19]

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   a_pins_off_disabled: // [RULE1]
   assert property (!q.cr.enable |=> !line_o.scl_oe && !line_o.sda_oe)
      else $error("line driven while controller disabled");
   a_half_bounded: // [RULE2]
   assert property ((q.st == ST_MBIT && !q.ph && $stable(q.cr.rate)) |-> q.cnt <= half_last(q.cr.rate))
      else $error("half-period counter ran past its rate limit");
   a_start_needs_idle: // [RULE3]
   assert property ((q.st == ST_MWAIT && !bus_idle) |=> q.st != ST_MSTART)
      else $error("start issued on a busy bus");
   a_addr_done_pend: // [RULE4]
   assert property ((q.st == ST_MBIT && q.addr && q.ph && q.s2.scl && tick && q.bitn == BIT_ACK
      && q.cr.enable && !bus_req.wr) |=> (!q.sta && q.pend && q.st == ST_MHOLD))
      else $error("address phase did not end in a hold");
   a_hold_pulls_scl: // [RULE5]
   assert property ((q.cr.enable && q.st == ST_MHOLD) |=> line_o.scl_oe)
      else $error("clock not held low during pending");
   a_stop_needs_busy: // [RULE8]
   assert property ((bus_req.wr && bus_req.addr == OFS_SR && q.cr.master && !q.busy && !q.stp) |=> !q.stp)
      else $error("stop request accepted while not busy");
   a_no_start_midbyte: // [RULE10]
   assert property ((bus_req.wr && bus_req.addr == OFS_SR && q.cr.master && q.st == ST_MBIT && !q.addr
      && q.cr.enable) |=> q.sta == $past(q.sta))
      else $error("start request changed during a byte");
   a_busy_in_byte: // [RULE11]
   assert property ((q.cr.master && q.st == ST_MBIT) |-> q.busy)
      else $error("byte transfer without busy flag");
   a_slave_match: // [RULE12]
   assert property ((!q.cr.master && $rose(q.sta)) |-> (q.pend && q.busy && q.st == ST_SHOLD))
      else $error("slave start flag without pending hold");
   a_irq_on_pend: // [RULE19]
   assert property ((q.pend && q.cr.irq_en) |-> irq)
      else $error("pending flag raised no interrupt");
   a_disable_clears: // [RULE20]
   assert property (!q.cr.enable |-> !(q.pend || q.sta || q.stp || q.ack || q.busy))
      else $error("flags survive disable");

   c_master_hold: cover property (q.cr.master && $rose(q.pend));
   c_slave_match: cover property (!q.cr.master && $rose(q.sta));
   c_slave_stop: cover property (!q.cr.master && $rose(q.stp));
   c_master_stop: cover property (q.st == ST_MSTOP ##1 q.st == ST_IDLE);
endmodule

/* pkg/twmsc_pkg.sv */
package twmsc_pkg;
   // Overview of operation
   // [RULE1] enabling the controller turns both line pins into open-drain drivers
   // [RULE2] master rate field: 00 100 kHz, 01 400 kHz, 10 1 MHz
   // [RULE3] bus counts as idle only while clock and data are both high
   // [RULE4] start request waits for idle bus, sends start and address, then self-clears
   // [RULE5] master sets pending and holds clock low after address acknowledge
   // [RULE6] master write: clearing pending sends loaded byte, samples ack, holds again
   // [RULE7] master read: clear receives byte and holds; second clear sends chosen ack
   // [RULE8] stop request accepted only while busy; sent after pending clears, then self-clears
   // [RULE9] start plus stop while busy sends stop, start, address, then pending
   // [RULE10] repeated start allowed between bytes; start and stop writes refused mid-byte
   // [RULE11] busy set after start sent or matched; cleared on stop or disable
   // [RULE12] slave address match sets start flag and pending, clock held low
   // [RULE13] own address in identity bits 7..1; bit 0 adds general call address zero
   // [RULE14] slave transmit: clear sends byte, samples master ack, pending and hold
   // [RULE15] slave receive: byte received sets pending and holds until ack chosen
   // [RULE16] slave start and stop flags set by hardware, cleared by software
   // [RULE17] slave start seen mid-transfer abandons transfer and waits for address
   // [RULE18] ack control drives ninth bit when receiving, captures it when sending
   // [RULE19] interrupt flag on pending, or on stop flag in slave mode; enable gates it
   // [RULE20] disabling clears pending, start, stop and ack control
   // [RULE21] direction 0 write, 1 read; software-set as master, received as slave
   // [RULE22] data register write gives next byte; read gives last byte
   // [RULE23] reserved rate code falls back to 100 kHz
   localparam int unsigned REF_CLK_HZ = 200_000_000;
   localparam int unsigned RATE_STD_HZ = 100_000;
   localparam int unsigned RATE_FAST_HZ = 400_000;
   localparam int unsigned RATE_FPLUS_HZ = 1_000_000;
   localparam int CNT_W = 10;
   localparam logic [15:0] OFS_CR = 16'h4028;
   localparam logic [15:0] OFS_ID = 16'h4029;
   localparam logic [15:0] OFS_DR = 16'h402A;
   localparam logic [15:0] OFS_SR = 16'h402B;
   localparam logic [7:0] ID_RESET = 8'hAA;
   localparam int CR_EN = 7;
   localparam int CR_MS = 6;
   localparam int CR_RATE_HI = 2;
   localparam int CR_RATE_LO = 1;
   localparam int CR_IE = 0;
   localparam int ID_GC = 0;
   localparam int SR_DIR = 6;
   localparam int SR_STA = 4;
   localparam int SR_STP = 3;
   localparam int SR_PEND = 2;
   localparam int SR_ACK = 1;
   localparam int BYTE_MSB = 7;
   localparam logic [1:0] RATE_FAST = 2'h1;
   localparam logic [1:0] RATE_FPLUS = 2'h2;
   localparam logic [6:0] GC_ADDR = 7'h00;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   typedef enum logic [3:0] {
      ST_IDLE, ST_MWAIT, ST_MSTART, ST_MBIT, ST_MHOLD, ST_MSTOP, ST_MRESTART, ST_SBIT, ST_SHOLD
   } twmsc_state_e;
   typedef struct packed {logic scl; logic sda;} twmsc_line_s;
   typedef struct packed {logic scl_o; logic scl_oe; logic sda_o; logic sda_oe;} twmsc_pin_out_s;
   typedef struct packed {logic [15:0] addr; logic [7:0] wdata; logic wr; logic rd;} twmsc_bus_req_s;
   typedef struct packed {logic enable; logic master; logic [1:0] rate; logic irq_en;} twmsc_ctrl_s;
endpackage

/* testbench/twmsc_slave_model.sv */
`timescale 1ns/10ps
module twmsc_slave_model #(
   parameter logic [6:0] ADDR = 7'h3B
) (
   // resolved lines
   input wire logic scl,
   input wire logic sda,
   // line pull-downs
   output logic scl_pull,
   output logic sda_pull,
   // behaviour and observations
   input wire logic slow,
   input wire logic [7:0] tx_byte,
   output logic [7:0] rx_byte,
   output logic ack_seen,
   output logic [7:0] stop_cnt
);
   logic [7:0] sh;
   logic sel;
   logic rd;
   logic addr_ph;
   int bit_n;
   initial begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
      rx_byte = 8'h00;
      ack_seen = 1'b0;
      stop_cnt = 8'h00;
      sel = 1'b0;
      rd = 1'b0;
      addr_ph = 1'b0;
      bit_n = 0;
      sh = 8'h00;
   end
   // small delay rejects sda moving in the same step as a scl fall
   always @(negedge sda) begin
      #1;
      if (scl === 1'b1) begin
         bit_n = 0;
         addr_ph = 1'b1;
         sel = 1'b0;
      end
   end
   always @(posedge sda) begin
      #1;
      if (scl === 1'b1) begin
         stop_cnt = stop_cnt + 8'h01;
         sel = 1'b0;
         addr_ph = 1'b0;
      end
   end
   always @(posedge scl) begin
      if (bit_n < 8) begin
         sh = {sh[6:0], sda};
      end else if (sel && rd && !addr_ph) begin
         ack_seen = sda;
         sel = !sda;
      end
      bit_n = bit_n + 1;
   end
   always @(negedge scl) begin
      sda_pull = 1'b0;
      if (bit_n == 8) begin
         if (addr_ph) begin
            sel = sh[7:1] == ADDR;
            rd = sh[0];
         end else if (sel && !rd) begin
            rx_byte = sh;
         end
         sda_pull = sel && (addr_ph || !rd);
      end else if (bit_n == 9) begin
         bit_n = 0;
         addr_ph = 1'b0;
      end
      if (sel && rd && !addr_ph && bit_n < 8) begin
         sda_pull = !tx_byte[7 - bit_n];
      end
      // clock stretching, held past the master's low phase
      if (slow) begin
         scl_pull = 1'b1;
         #300 scl_pull = 1'b0;
      end
   end
endmodule

/* testbench/test_two_wire_master_slave_controller.sv */
`timescale 1ns/10ps
module test_two_wire_master_slave_controller;
   import twmsc_pkg::*;
   localparam int CLK = 8_000_000;
   logic ref_clk;
   logic rst_n = 1'b0;
   twmsc_bus_req_s bus_req = '0;
   logic [7:0] bus_rdata;
   twmsc_line_s line_i;
   twmsc_pin_out_s line_o;
   logic open_drain_en;
   logic irq;
   logic scl_w;
   logic sda_w;
   logic m_scl = 1'b0;
   logic m_sda = 1'b0;
   logic slow = 1'b0;
   logic p_scl;
   logic p_sda;
   logic p_ack;
   logic [7:0] p_tx = 8'h00;
   logic [7:0] p_rx;
   logic [7:0] p_stops;
   int hi_run = 0;
   int last_hi = 0;
   int bad_count = 0;
   int comparisons = 0;
   // open-drain lines with pull-ups
   assign scl_w = !(line_o.scl_oe || p_scl || m_scl);
   assign sda_w = !(line_o.sda_oe || p_sda || m_sda);
   assign line_i = '{scl: scl_w, sda: sda_w};
   twmsc_ctrl #(.CLK_HZ(CLK)) dut_u (
      .ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
      .line_i(line_i), .line_o(line_o), .open_drain_en(open_drain_en), .irq(irq)
   );
   twmsc_slave_model #(.ADDR(7'h3B)) partner_u (
      .scl(scl_w), .sda(sda_w), .scl_pull(p_scl), .sda_pull(p_sda), .slow(slow),
      .tx_byte(p_tx), .rx_byte(p_rx), .ack_seen(p_ack), .stop_cnt(p_stops)
   );
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      if (scl_w) begin
         hi_run <= hi_run + 1;
      end else if (hi_run != 0) begin
         last_hi <= hi_run;
         hi_run <= 0;
      end
   end
   function automatic int half(input int rt);
      int f;
      f = rt == 1 ? RATE_FAST_HZ : rt == 2 ? RATE_FPLUS_HZ : RATE_STD_HZ;
      return (CLK + 2 * f - 1) / (2 * f);
   endfunction
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      bus_req <= '0;
   endtask
   task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      bus_req <= '0;
      @(posedge ref_clk);
      d = bus_rdata;
   endtask
   task automatic wait_st(input logic [7:0] m, input logic [7:0] v);
      logic [7:0] s;
      s = ~v;
      for (int i = 0; i < 600 && (s & m) !== v; i++) reg_rd(OFS_SR, s);
      chk(s & m, v);
   endtask
   // bench acting as a far-side master at 125 ns per bit
   task automatic bm_bit(input logic b, output logic r);
      m_sda = !b;
      #62.5 m_scl = 1'b0;
      for (int k = 0; k < 4000 && scl_w !== 1'b1; k++) #5;
      #62.5 r = sda_w;
      m_scl = 1'b1;
   endtask
   task automatic bm_byte(input logic [7:0] v);
      logic r;
      for (int i = 7; i >= 0; i--) bm_bit(v[i], r);
   endtask
   task automatic bm_start;
      m_sda = 1'b1;
      #62.5 m_scl = 1'b1;
   endtask
   task automatic bm_stop;
      m_sda = 1'b1;
      #62.5 m_scl = 1'b0;
      #62.5 m_sda = 1'b0;
      #62.5;
   endtask
   initial begin
      #400_000;
      bad_count++;
      tally_and_finish;
   end
   initial begin
      logic [7:0] s;
      logic [7:0] d;
      logic [7:0] n;
      logic r;
      void'($urandom(53));
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         reg_rd(OFS_CR + 16'(i), s);
         chk(s, i == 1 ? ID_RESET : 8'h00);
      end
      reg_wr(OFS_CR, 8'hC1);
      @(posedge ref_clk);
      chk({7'h00, open_drain_en}, 8'h01);
      reg_wr(OFS_SR, 8'h08);
      reg_rd(OFS_SR, s);
      chk(s, 8'h00);
      reg_wr(OFS_ID, {7'h3B, 1'b0});
      for (int rt = 0; rt < 4; rt++) begin
         reg_wr(OFS_CR, {5'b11000, rt[1:0], 1'b1});
         slow = rt[0];
         m_sda = rt == 0;
         reg_wr(OFS_SR, 8'h10);
         if (rt == 0) begin
            repeat (200) @(posedge ref_clk);
            chk({6'h00, line_o.scl_oe, line_o.sda_oe}, 8'h00);
            m_sda = 1'b0;
         end
         wait_st(8'h04, 8'h04);
         reg_rd(OFS_SR, s);
         chk(s, 8'h85);
         chk({7'h00, irq}, 8'h01);
         chk(8'(last_hi >= half(rt) && last_hi <= half(rt) + 5), 8'h01);
         d = 8'($urandom);
         reg_wr(OFS_DR, d);
         reg_wr(OFS_SR, 8'h00);
         wait_st(8'h04, 8'h04);
         chk(p_rx, d);
         if (rt == 1) begin
            n = p_stops;
            reg_wr(OFS_SR, 8'h18);
            wait_st(8'h04, 8'h04);
            reg_rd(OFS_SR, s);
            chk(s, 8'h85);
            chk(p_stops - n, 8'h01);
         end
         if (rt == 2) begin
            p_tx <= 8'($urandom);
            reg_wr(OFS_SR, 8'h50);
            wait_st(8'h04, 8'h04);
            reg_rd(OFS_SR, s);
            chk(s, 8'hC5);
            reg_wr(OFS_SR, 8'h40);
            wait_st(8'h04, 8'h04);
            reg_rd(OFS_DR, s);
            chk(s, p_tx);
            reg_wr(OFS_SR, 8'h42);
            wait_st(8'h04, 8'h04);
            chk({7'h00, p_ack}, 8'h01);
         end
         reg_wr(OFS_SR, 8'h08);
         wait_st(8'hB9, 8'h00);
      end
      slow = 1'b0;
      reg_wr(OFS_CR, 8'h81);
      for (int c = 0; c < 3; c++) begin
         reg_wr(OFS_ID, {7'h21, c == 1});
         bm_start;
         bm_byte(c == 0 ? 8'h42 : 8'h00);
         if (c != 2) begin
            wait_st(8'h04, 8'h04);
            reg_rd(OFS_SR, s);
            chk(s, 8'h95);
            chk({7'h00, irq}, 8'h01);
            reg_wr(OFS_SR, 8'h00);
         end
         bm_bit(1'b1, r);
         chk({7'h00, r}, {7'h00, c == 2});
         if (c != 2) begin
            d = 8'($urandom);
            bm_byte(d);
            wait_st(8'h04, 8'h04);
            reg_rd(OFS_DR, s);
            chk(s, d);
            reg_wr(OFS_SR, 8'h02);
            bm_bit(1'b1, r);
            chk({7'h00, r}, 8'h01);
         end
         bm_stop;
         wait_st(8'h89, c == 2 ? 8'h00 : 8'h09);
         reg_wr(OFS_SR, 8'h00);
      end
      bm_start;
      bm_byte(8'h42);
      wait_st(8'h04, 8'h04);
      reg_wr(OFS_SR, 8'h06);
      reg_wr(OFS_CR, 8'h00);
      reg_rd(OFS_SR, s);
      chk(s, 8'h00);
      chk({6'h00, open_drain_en, irq}, 8'h00);
      bm_stop;
      tally_and_finish;
   end
endmodule
